// ---- verilog/pdcs_top.sv ----
// pll divider registers, phase detector divisor selection and buffered clock pin mux
`timescale 1ns/1ps

// How it works
// - full reference divider is 9 bits, feedback 10 bits, high bits above low byte
// - master and pseudo-master: reference divided by programmed reference divider
// - slave: external pixel clock used, divided by the external clock divide field
// - master and pseudo-master: vco divided by programmed feedback divider
// - slave: feedback division fixed at one, programmed value ignored
// - pixel clock is reference times (feedback+2) over (reference+2)
// - 3-bit select: 000 crystal, 010 divided vco, 011 field id
// - 001, 100, 101 reserved for test; 110 hsync, 111 vsync
// - separate 3-bit factor sets the divided vco frequency
// - factor codes map to 2.5, 3, 3.5, 4, 4.5, 5, 6, 7
module pdcs_top
  import pdcs_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic [7:0]    regAddr,
  input  wire logic          regWrEn,
  input  wire logic [7:0]    regWrData,
  output logic      [7:0]    regRdData,
  input  wire pdcs_mode_t    clockMode,
  input  wire logic [3:0]    externalClockDivideSel,
  input  wire logic          vcoTick,
  input  wire pdcs_pin_src_t pinSrcAsync,
  output pdcs_pll_cfg_t      pllCfg,
  output logic               clockPinOut
);

  logic [4:0]    divHigh_q, divHigh_d;
  logic [7:0]    refLow_q, refLow_d;
  logic [7:0]    fbLow_q, fbLow_d;
  logic [5:0]    clkSel_q, clkSel_d;
  pdcs_pin_src_t syncA_q, syncB_q;
  logic [3:0]    vcoCnt_q, vcoCnt_d;
  logic          vcoPhase_q, vcoPhase_d;
  logic          vcoOut_q, vcoOut_d;
  logic          pinOut_q, pinOut_d;
  pdcs_pll_cfg_t pllCfg_q, pllCfg_d;

  logic [8:0]    refDivFull;
  logic [9:0]    fbDivFull;
  logic [4:0]    factorX2;
  logic [3:0]    periodLen;
  pdcs_src_t     srcSel;
  logic [2:0]    vcoDivideFactorSel;

  // twice the vco division factor, so half-integer factors stay integral
  function automatic logic [4:0] factor_x2(input logic [2:0] sel);
    unique case (sel)
      3'h0: factor_x2 = 5'h05;
      3'h1: factor_x2 = 5'h06;
      3'h2: factor_x2 = 5'h07;
      3'h3: factor_x2 = 5'h08;
      3'h4: factor_x2 = 5'h09;
      3'h5: factor_x2 = 5'h0A;
      3'h6: factor_x2 = 5'h0C;
      3'h7: factor_x2 = 5'h0E;
    endcase
  endfunction

  // register writes; reserved bits are stored as written and read back
  always_comb
  begin
    divHigh_d = divHigh_q;
    refLow_d  = refLow_q;
    fbLow_d   = fbLow_q;
    clkSel_d  = clkSel_q;
    if (regWrEn)
    begin
      unique case (regAddr)
        ADDR_DIV_HIGH: divHigh_d = regWrData[4:0];
        ADDR_REF_LOW:  refLow_d  = regWrData;
        ADDR_FB_LOW:   fbLow_d   = regWrData;
        ADDR_CLK_SEL:  clkSel_d  = regWrData[5:0];
        default:       divHigh_d = divHigh_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divHigh_q <= RST_DIV_HIGH;
      refLow_q  <= RST_REF_LOW;
      fbLow_q   <= RST_FB_LOW;
      clkSel_q  <= RST_CLK_SEL;
    end
    else
    begin
      divHigh_q <= divHigh_d;
      refLow_q  <= refLow_d;
      fbLow_q   <= fbLow_d;
      clkSel_q  <= clkSel_d;
    end
  end

  // unmapped addresses read as zero, bits above a register's width read as zero
  always_comb
  begin
    unique case (regAddr)
      ADDR_DIV_HIGH: regRdData = {3'h0, divHigh_q};
      ADDR_REF_LOW:  regRdData = refLow_q;
      ADDR_FB_LOW:   regRdData = fbLow_q;
      ADDR_CLK_SEL:  regRdData = {2'h0, clkSel_q};
      default:       regRdData = 8'h00;
    endcase
  end

  assign refDivFull = {divHigh_q[POS_REF_DIV_BIT8], refLow_q};
  assign fbDivFull  = {divHigh_q[POS_FB_DIV_BIT9], divHigh_q[POS_FB_DIV_BIT8], fbLow_q};

  // divisors toward the loop; slave mode swaps in the external clock path
  always_comb
  begin
    if (clockMode == PDCS_MODE_SLAVE)
    begin
      pllCfg_d.refDiv = {5'h00, externalClockDivideSel};
      pllCfg_d.fbDiv  = SLAVE_FB_DIV;
    end
    else
    begin
      pllCfg_d.refDiv = refDivFull;
      pllCfg_d.fbDiv  = fbDivFull;
    end
    pllCfg_d.pixelMul = fbDivFull + DIV_OFFSET;
    pllCfg_d.pixelDiv = {1'b0, refDivFull} + DIV_OFFSET;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pllCfg_q <= '0;
    else
      pllCfg_q <= pllCfg_d;
  end

  assign pllCfg = pllCfg_q;

  // pin-level sources cross in through two flops each
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_q <= '0;
      syncB_q <= '0;
    end
    else
    begin
      syncA_q <= pinSrcAsync;
      syncB_q <= syncA_q;
    end
  end

  assign vcoDivideFactorSel = clkSel_q[POS_SHF_LSB +: 3];
  assign srcSel             = pdcs_src_t'(clkSel_q[POS_SRC_LSB +: 3]);
  assign factorX2           = factor_x2(vcoDivideFactorSel);
  // odd factorX2 means a half-integer factor: short and long periods alternate
  assign periodLen = vcoPhase_q ? 4'((factorX2 + 5'h01) >> 1) : 4'(factorX2 >> 1);

  // vco divider counts vco ticks; output is high for the first half of each period, rounded down to whole ticks
  always_comb
  begin
    vcoCnt_d   = vcoCnt_q;
    vcoPhase_d = vcoPhase_q;
    vcoOut_d   = vcoOut_q;
    if (vcoTick)
    begin
      if (vcoCnt_q >= periodLen - 4'h1)
      begin
        vcoCnt_d   = 4'h0;
        vcoPhase_d = factorX2[0] ? ~vcoPhase_q : 1'b0;
        vcoOut_d   = 1'b1;
      end
      else
      begin
        vcoCnt_d = vcoCnt_q + 4'h1;
        vcoOut_d = (vcoCnt_q + 4'h1) < (periodLen >> 1);
      end
    end
  end

  // codes reserved for test drive the pin low; a glitch-free mux is the analog side's job
  always_comb
  begin
    unique case (srcSel)
      PDCS_SRC_XTAL:   pinOut_d = syncB_q.xtal;
      PDCS_SRC_VCODIV: pinOut_d = vcoOut_q;
      PDCS_SRC_FIELD:  pinOut_d = syncB_q.fieldId;
      PDCS_SRC_HSYNC:  pinOut_d = syncB_q.hsync;
      PDCS_SRC_VSYNC:  pinOut_d = syncB_q.vsync;
      PDCS_SRC_TEST1,
      PDCS_SRC_TEST4,
      PDCS_SRC_TEST5:  pinOut_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vcoCnt_q   <= 4'h0;
      vcoPhase_q <= 1'b0;
      vcoOut_q   <= 1'b0;
      pinOut_q   <= 1'b0;
    end
    else
    begin
      vcoCnt_q   <= vcoCnt_d;
      vcoPhase_q <= vcoPhase_d;
      vcoOut_q   <= vcoOut_d;
      pinOut_q   <= pinOut_d;
    end
  end

  assign clockPinOut = pinOut_q;

endmodule // pdcs_top

// ---- common/pdcs_pkg.sv ----
// shared constants and types for the pll divider and clock pin select block
package pdcs_pkg;

  localparam logic [7:0] ADDR_DIV_HIGH  = 8'h13;
  localparam logic [7:0] ADDR_REF_LOW   = 8'h14;
  localparam logic [7:0] ADDR_FB_LOW    = 8'h15;
  localparam logic [7:0] ADDR_CLK_SEL   = 8'h17;

  localparam logic [4:0] RST_DIV_HIGH   = 5'h00;
  localparam logic [7:0] RST_REF_LOW    = 8'h41;
  localparam logic [7:0] RST_FB_LOW     = 8'h80;
  localparam logic [5:0] RST_CLK_SEL    = 6'h00;

  // field positions in the high-bits register
  localparam int POS_REF_DIV_BIT8       = 0;
  localparam int POS_FB_DIV_BIT8        = 1;
  localparam int POS_FB_DIV_BIT9        = 2;
  localparam int POS_RSVD_LO            = 3;
  localparam int POS_RSVD_HI            = 4;
  // field positions in the clock select register
  localparam int POS_SRC_LSB            = 0;
  localparam int POS_SHF_LSB            = 3;

  localparam logic [9:0] SLAVE_FB_DIV   = 10'h001;
  localparam logic [9:0] DIV_OFFSET     = 10'h002;

  typedef enum logic [1:0] {
    PDCS_MODE_MASTER = 2'h0,
    PDCS_MODE_PSEUDO = 2'h1,
    PDCS_MODE_SLAVE  = 2'h3
  } pdcs_mode_t;

  typedef enum logic [2:0] {
    PDCS_SRC_XTAL   = 3'h0,
    PDCS_SRC_TEST1  = 3'h1,
    PDCS_SRC_VCODIV = 3'h2,
    PDCS_SRC_FIELD  = 3'h3,
    PDCS_SRC_TEST4  = 3'h4,
    PDCS_SRC_TEST5  = 3'h5,
    PDCS_SRC_HSYNC  = 3'h6,
    PDCS_SRC_VSYNC  = 3'h7
  } pdcs_src_t;

  // divider values handed to the analog loop
  typedef struct packed {
    logic [8:0] refDiv;
    logic [9:0] fbDiv;
    logic [9:0] pixelMul;
    logic [9:0] pixelDiv;
  } pdcs_pll_cfg_t;

  // level inputs feeding the clock pin mux
  typedef struct packed {
    logic xtal;
    logic fieldId;
    logic hsync;
    logic vsync;
  } pdcs_pin_src_t;

endpackage

// ---- test/pdcs_top_asserts.sv ----
// concurrent port checks for the pll divider and clock pin select block
`timescale 1ns/1ps
module pdcs_top_asserts
  import pdcs_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire logic [7:0]    regAddr,
  input wire logic          regWrEn,
  input wire logic [7:0]    regWrData,
  input wire logic [7:0]    regRdData,
  input wire pdcs_mode_t    clockMode,
  input wire logic [3:0]    externalClockDivideSel,
  input wire pdcs_pin_src_t pinSrcAsync,
  input wire pdcs_pll_cfg_t pllCfg,
  input wire logic          clockPinOut
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ref_rd; (regWrEn && regAddr == ADDR_REF_LOW) ##1 (regAddr == ADDR_REF_LOW)
    |-> regRdData == $past(regWrData); endproperty
  a_ref_rd: assert property (p_ref_rd) else $error("reference low byte not stored");
  property p_ref_div; (clockMode != PDCS_MODE_SLAVE && regAddr == ADDR_REF_LOW)
    |=> pllCfg.refDiv[7:0] == $past(regRdData); endproperty
  a_ref_div: assert property (p_ref_div) else $error("reference divisor wrong");
  property p_slave_ref; clockMode == PDCS_MODE_SLAVE
    |=> pllCfg.refDiv == {5'h00, $past(externalClockDivideSel)}; endproperty
  a_slave_ref: assert property (p_slave_ref) else $error("slave divisor wrong");
  property p_fb_high; (clockMode != PDCS_MODE_SLAVE && regAddr == ADDR_DIV_HIGH)
    |=> pllCfg.fbDiv[9:8] == $past(regRdData[2:1]) && pllCfg.refDiv[8] == $past(regRdData[0]); endproperty
  a_fb_high: assert property (p_fb_high) else $error("divider high bits wrong");
  property p_slave_fb; clockMode == PDCS_MODE_SLAVE |=> pllCfg.fbDiv == SLAVE_FB_DIV; endproperty
  a_slave_fb: assert property (p_slave_fb) else $error("slave feedback not one");
  property p_pixel; clockMode != PDCS_MODE_SLAVE |=> pllCfg.pixelMul == pllCfg.fbDiv + DIV_OFFSET
    && pllCfg.pixelDiv == {1'b0, pllCfg.refDiv} + DIV_OFFSET; endproperty
  a_pixel: assert property (p_pixel) else $error("pixel ratio wrong");
  property p_xtal; (regAddr == ADDR_CLK_SEL && regRdData[2:0] == PDCS_SRC_XTAL)[*4]
    |-> clockPinOut == $past(pinSrcAsync.xtal, 3); endproperty
  a_xtal: assert property (p_xtal) else $error("crystal not on pin");
  property p_test_codes; (regAddr == ADDR_CLK_SEL && regRdData[2:0] inside {3'h1, 3'h4, 3'h5})[*4]
    |-> !clockPinOut; endproperty
  a_test_codes: assert property (p_test_codes) else $error("test code drives pin");
endmodule // pdcs_top_asserts
bind pdcs_top pdcs_top_asserts pdcs_top_asserts_i (.ref_clk, .rst_n, .regAddr, .regWrEn, .regWrData,
  .regRdData, .clockMode, .externalClockDivideSel, .pinSrcAsync, .pllCfg, .clockPinOut);

// ---- test/pdcs_host.sv ----
// host model that programs the block registers
`timescale 1ns/1ps
module pdcs_host
  import pdcs_pkg::*;
(
  input  wire logic       ref_clk,
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData
);
  initial
  begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr <= a;
    regWrData <= (a == ADDR_DIV_HIGH) ? (d & 8'h07) : d;
    regWrEn <= 1'b1;
    @(negedge ref_clk);
    regWrEn <= 1'b0;
    // stale data is inverted so nothing leans on it
    regWrData <= ~regWrData;
  endtask
  task automatic look(input logic [7:0] a);
    @(negedge ref_clk);
    regAddr <= a;
  endtask
endmodule // pdcs_host

// ---- test/pdcs_top_test.sv ----
// self-checking bench for the pll divider and clock pin select block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pdcs_top_test;
  import pdcs_pkg::*;
  logic          ref_clk, rst_n, regWrEn, vcoTick, clockPinOut;
  logic [7:0]    regAddr, regWrData, regRdData;
  logic [3:0]    externalClockDivideSel;
  pdcs_mode_t    clockMode;
  pdcs_pin_src_t pinSrcAsync;
  pdcs_pll_cfg_t pllCfg;
  int            bad_count, cmp_count, cyc, n, m;
  logic          tickSlow;
  int            srcOf[8] = '{3, -1, -1, 2, -1, -1, 1, 0};
  int            twice[8] = '{5, 6, 7, 8, 9, 10, 12, 14};
  pdcs_host pdcs_host_i (.ref_clk, .regAddr, .regWrEn, .regWrData);
  pdcs_top pdcs_top_i (.ref_clk, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdData, .clockMode,
    .externalClockDivideSel, .vcoTick, .pinSrcAsync, .pllCfg, .clockPinOut);
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end
  // the slow pass ticks the vco every other cycle so the divider's hold path is used
  always @(negedge ref_clk)
    vcoTick <= tickSlow ? ~vcoTick : 1'b1;
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    pdcs_host_i.look(a);
    #1 `CHK(regRdData, e)
  endtask
  task automatic chk_cfg(input pdcs_pll_cfg_t e);
    repeat (2) @(negedge ref_clk);
    `CHK(pllCfg, e)
  endtask
  // bounded wait for a rising pin edge, counting cycles into k
  task automatic rise(inout int k);
    logic p;
    p = clockPinOut;
    repeat (40)
    begin
      @(negedge ref_clk);
      k++;
      if (clockPinOut && !p) return;
      p = clockPinOut;
    end
    `CHK(1'b0, 1'b1)
  endtask
  initial
  begin
    rst_n = 1'b0;
    vcoTick = 1'b0;
    tickSlow = 1'b0;
    clockMode = PDCS_MODE_MASTER;
    externalClockDivideSel = 4'h0;
    pinSrcAsync = '0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    chk_rd(ADDR_DIV_HIGH, 8'h00);
    chk_rd(ADDR_REF_LOW, 8'h41);
    chk_rd(ADDR_FB_LOW, 8'h80);
    chk_rd(ADDR_CLK_SEL, 8'h00);
    `CHK(pllCfg, {9'h041, 10'h080, 10'h082, 10'h043})
    pdcs_host_i.wr(ADDR_FB_LOW, 8'h14);
    pdcs_host_i.wr(ADDR_REF_LOW, 8'h0D);
    chk_cfg({9'h00D, 10'h014, 10'h016, 10'h00F});
    pdcs_host_i.wr(ADDR_FB_LOW, 8'h87);
    pdcs_host_i.wr(ADDR_REF_LOW, 8'h39);
    pdcs_host_i.wr(ADDR_DIV_HIGH, 8'hFD);
    chk_cfg({9'h139, 10'h287, 10'h289, 10'h13B});
    chk_rd(ADDR_DIV_HIGH, 8'h05);
    clockMode = PDCS_MODE_PSEUDO;
    chk_cfg({9'h139, 10'h287, 10'h289, 10'h13B});
    clockMode = PDCS_MODE_SLAVE;
    externalClockDivideSel = 4'hA;
    chk_cfg({9'h00A, 10'h001, 10'h289, 10'h13B});
    pdcs_host_i.wr(8'h16, 8'hFF);
    chk_rd(8'h16, 8'h00);
    for (int c = 0; c < 8; c++)
      if (c != 2)
      begin
        pdcs_host_i.wr(ADDR_CLK_SEL, 8'(c));
        for (int b = 0; b < 4; b++)
        begin
          pinSrcAsync = 4'(1 << b);
          repeat (5) @(negedge ref_clk);
          `CHK(clockPinOut, 1'(srcOf[c] == b))
        end
      end
    pinSrcAsync = '0;
    for (int s = 0; s < 2; s++)
    begin
      tickSlow <= 1'(s);
      for (int f = 0; f < 8; f++)
      begin
        pdcs_host_i.wr(ADDR_CLK_SEL, 8'(f * 8 + 2));
        `CHK(regRdData, 8'(f * 8 + 2))
        rise(n);
        n = 0;
        rise(n);
        m = n;
        rise(n);
        `CHK(1'(m == (twice[f] / 2) * (s + 1) || m == ((twice[f] + 1) / 2) * (s + 1)), 1'b1)
        `CHK(n, twice[f] * (s + 1))
      end
    end
    close_out();
  end
endmodule // pdcs_top_test
